// ===== rsc_pkg.sv
// package of constants for the reset source controller
package rsc_pkg;
   // reset cause flag positions
   localparam int CAUSE_W = 6;
   localparam int CAUSE_EXT = 0;
   localparam int CAUSE_POR = 1;
   localparam int CAUSE_DRP = 2;
   localparam int CAUSE_SW = 3;
   localparam int CAUSE_WDT = 4;
   localparam int CAUSE_LDO = 5;
   localparam logic [5:0] CAUSE_RST_VAL = 6'h00;
   // release synchroniser depth
   localparam int SYNC_STAGES = 3;
   // watchdog defaults
   localparam int WDT_W = 32;
   localparam logic [31:0] WDT_RELOAD_RST = 32'hffffffff;
   // per-register peripheral reset width and register count
   localparam int PERIPH_W = 32;
   localparam int PERIPH_REGS = 3;
   // sequencer states, gray coded along the path
   typedef enum logic [1:0] {
      RSC_HOLD = 2'b00,
      RSC_FETCH = 2'b01,
      RSC_RUN = 2'b11
   } rsc_state_t;
endpackage

// ===== rsc_rel_sync.sv
// reset release synchroniser: async assert, clocked release
`timescale 1ns/1ps
module rsc_rel_sync #(
   parameter int STAGES = rsc_pkg::SYNC_STAGES
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   output logic srst_n_o
);
   logic [STAGES-1:0] sync_r;

   // first stage feeds only the next stage
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_r <= '0;
      end else begin
         sync_r <= {sync_r[STAGES-2:0], 1'b1};
      end
   end

   assign srst_n_o = sync_r[STAGES-1];

   AST_REL_LOW: assert property (@(posedge core_clk_i)
      !arst_n_i |=> !srst_n_o)
      else $error("release not held low under reset");
endmodule

// ===== rsc_top.sv
// reset source controller: combines sources, sequences release, cause flags
`timescale 1ns/1ps
module rsc_top #(
   parameter int NPER = rsc_pkg::PERIPH_W
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic ext_rst_n_i,
   input wire logic supply_droop_i,
   input wire logic droop_reset_enable_i,
   input wire logic system_reset_request_i,
   input wire logic [NPER-1:0] periph_reset_ctrl_0_i,
   input wire logic [NPER-1:0] periph_reset_ctrl_1_i,
   input wire logic [NPER-1:0] periph_reset_ctrl_2_i,
   input wire logic wdt_enable_i,
   input wire logic wdt_reset_enable_i,
   input wire logic [31:0] watchdog_reload_value_i,
   input wire logic wdt_int_clear_i,
   input wire logic wdt_service_i,
   input wire logic cause_clear_i,
   input wire logic [5:0] cause_clear_mask_i,
   input wire logic test_mode_pin_0_i,
   input wire logic test_mode_pin_1_i,
   output logic core_rst_n_o,
   output logic tap_rst_n_o,
   output logic periph_rst_n_o,
   output logic [3*NPER-1:0] unit_rst_n_o,
   output logic core_fetch_o,
   output logic droop_int_o,
   output logic wdt_int_o,
   output logic [5:0] reset_cause_reg_o,
   output logic test_mode_bad_o
);
   // rstn_i is the power-on detector output; it only pulses at power-up
   logic sys_arst_n;
   logic sys_srst_n;
   logic droop_rst;
   logic wdt_rst_r;
   logic wdt_rst_nxt;
   logic swreq_r;
   logic [31:0] wdt_cnt_r;
   logic [31:0] wdt_cnt_nxt;
   logic wdt_int_r;
   logic wdt_zero;
   logic pend_ext_r;
   logic pend_drp_r;
   logic pend_sw_r;
   logic pend_wdt_r;
   logic por_seen_r;
   logic [5:0] cause_r;
   logic [5:0] cause_nxt;
   logic [5:0] cause_set;
   logic [3*NPER-1:0] per_bits;
   logic [3*NPER-1:0] per_prev_r;
   logic [3*NPER-1:0] per_rst_r;
   rsc_pkg::rsc_state_t state_r;
   rsc_pkg::rsc_state_t state_nxt;

   // droop only resets when software has enabled it
   assign droop_rst = supply_droop_i & droop_reset_enable_i;
   // all system sources merged asynchronously
   assign sys_arst_n = rstn_i & ext_rst_n_i & ~droop_rst
      & ~swreq_r & ~wdt_rst_r;

   // synchronised release of the combined system reset
   rsc_rel_sync #(
      .STAGES(rsc_pkg::SYNC_STAGES)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .arst_n_i(sys_arst_n),
      .srst_n_o(sys_srst_n)
   );

   // software request as a one-cycle pulse on the power-on domain; a flop
   // cleared by the reset it raises would pulse for zero time and be missed
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         swreq_r <= 1'b0;
      end else begin
         swreq_r <= system_reset_request_i & ~swreq_r;
      end
   end

   // watchdog down-counter; reload at every time-out and on service
   assign wdt_zero = (wdt_cnt_r == 32'h00000000);
   assign wdt_cnt_nxt = (wdt_zero | wdt_service_i) ? watchdog_reload_value_i
      : wdt_cnt_r - 32'h00000001;
   // second zero with interrupt still pending resets the system
   assign wdt_rst_nxt = wdt_enable_i & wdt_zero & wdt_int_r
      & wdt_reset_enable_i;

   // watchdog sits in the system domain, released after reset
   always_ff @(posedge core_clk_i or negedge sys_srst_n) begin
      if (!sys_srst_n) begin
         wdt_cnt_r <= rsc_pkg::WDT_RELOAD_RST;
         wdt_int_r <= 1'b0;
      end else begin
         if (wdt_enable_i) begin
            wdt_cnt_r <= wdt_cnt_nxt;
         end
         // set wins over clear
         if (wdt_enable_i & wdt_zero) begin
            wdt_int_r <= 1'b1;
         end else if (wdt_int_clear_i) begin
            wdt_int_r <= 1'b0;
         end
      end
   end

   // watchdog reset pulse kept on por only, so it survives its own reset
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wdt_rst_r <= 1'b0;
      end else begin
         wdt_rst_r <= wdt_rst_nxt & ~wdt_rst_r;
      end
   end

   // pending causes: which source held the system reset
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_ext_r <= 1'b0;
         pend_drp_r <= 1'b0;
         pend_sw_r <= 1'b0;
         pend_wdt_r <= 1'b0;
         por_seen_r <= 1'b1;
      end else if (state_r == rsc_pkg::RSC_FETCH) begin
         pend_ext_r <= 1'b0;
         pend_drp_r <= 1'b0;
         pend_sw_r <= 1'b0;
         pend_wdt_r <= 1'b0;
         por_seen_r <= 1'b0;
      end else begin
         pend_ext_r <= pend_ext_r | ~ext_rst_n_i;
         pend_drp_r <= pend_drp_r | droop_rst;
         pend_sw_r <= pend_sw_r | swreq_r;
         pend_wdt_r <= pend_wdt_r | wdt_rst_r;
      end
   end

   // cause flags at release of reset; power-on clears others
   always_comb begin
      cause_set = '0;
      cause_set[rsc_pkg::CAUSE_EXT] = pend_ext_r;
      cause_set[rsc_pkg::CAUSE_DRP] = pend_drp_r;
      cause_set[rsc_pkg::CAUSE_SW] = pend_sw_r;
      cause_set[rsc_pkg::CAUSE_WDT] = pend_wdt_r;
      cause_nxt = cause_r;
      if (cause_clear_i) begin
         cause_nxt = cause_nxt & ~cause_clear_mask_i;
      end
      if (state_r == rsc_pkg::RSC_FETCH) begin
         if (por_seen_r) begin
            cause_nxt = '0;
            cause_nxt[rsc_pkg::CAUSE_POR] = 1'b1;
         end else begin
            cause_nxt = cause_nxt | cause_set;
         end
      end
   end

   // cause register persists across non-power resets
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cause_r <= rsc_pkg::CAUSE_RST_VAL;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // release sequencer: hold, one fetch cycle, run
   always_comb begin
      case (state_r)
         rsc_pkg::RSC_HOLD: state_nxt = rsc_pkg::RSC_FETCH;
         rsc_pkg::RSC_FETCH: state_nxt = rsc_pkg::RSC_RUN;
         rsc_pkg::RSC_RUN: state_nxt = rsc_pkg::RSC_RUN;
         default: state_nxt = rsc_pkg::RSC_HOLD;
      endcase
   end

   // sequencer lives in the synchronised system domain
   always_ff @(posedge core_clk_i or negedge sys_srst_n) begin
      if (!sys_srst_n) begin
         state_r <= rsc_pkg::RSC_HOLD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // peripheral reset bits, one per unit, same positions as clock gates
   assign per_bits = {periph_reset_ctrl_2_i, periph_reset_ctrl_1_i,
      periph_reset_ctrl_0_i};

   // unit held in reset while its bit is set and for one cycle after the bit falls
   generate
      for (genvar g = 0; g < 3*NPER; g++) begin : g_unit
         always_ff @(posedge core_clk_i or negedge sys_srst_n) begin
            if (!sys_srst_n) begin
               per_prev_r[g] <= 1'b0;
               per_rst_r[g] <= 1'b1;
            end else begin
               per_prev_r[g] <= per_bits[g];
               per_rst_r[g] <= per_bits[g] | per_prev_r[g];
            end
         end
      end
   endgenerate

   // registered outputs; test port only follows power-on
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         core_rst_n_o <= 1'b0;
         tap_rst_n_o <= 1'b0;
         periph_rst_n_o <= 1'b0;
         unit_rst_n_o <= '0;
         core_fetch_o <= 1'b0;
         droop_int_o <= 1'b0;
         wdt_int_o <= 1'b0;
         reset_cause_reg_o <= rsc_pkg::CAUSE_RST_VAL;
         test_mode_bad_o <= 1'b0;
      end else begin
         core_rst_n_o <= sys_srst_n & sys_arst_n;
         tap_rst_n_o <= 1'b1;
         periph_rst_n_o <= sys_srst_n & sys_arst_n;
         unit_rst_n_o <= ~per_rst_r & {3*NPER{sys_srst_n & sys_arst_n}};
         core_fetch_o <= (state_r == rsc_pkg::RSC_FETCH);
         droop_int_o <= supply_droop_i & ~droop_reset_enable_i;
         wdt_int_o <= wdt_int_r;
         reset_cause_reg_o <= cause_r;
         test_mode_bad_o <= test_mode_pin_0_i | test_mode_pin_1_i;
      end
   end

   // checks
   AST_DROOP_HOLD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      droop_rst |=> !core_rst_n_o)
      else $error("core not reset during droop");
   AST_DROOP_OFF: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      supply_droop_i && !droop_reset_enable_i |=> droop_int_o)
      else $error("droop interrupt missing");
   AST_TAP_KEEP: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $past(tap_rst_n_o) |-> tap_rst_n_o)
      else $error("test port reset by non power-on source");
   AST_EXT_CORE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !ext_rst_n_i |=> !core_rst_n_o && !periph_rst_n_o)
      else $error("pin reset not applied");
   AST_POR_ONLY: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      core_fetch_o && $past(por_seen_r, 2) |-> ##1
      reset_cause_reg_o == 6'h02)
      else $error("power-on cause wrong");
   AST_STICKY: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !cause_clear_i && cause_r[rsc_pkg::CAUSE_EXT]
      |=> cause_r[rsc_pkg::CAUSE_EXT] || por_seen_r)
      else $error("cause flag lost");
   AST_WDT_RELOAD: assert property (@(posedge core_clk_i)
      disable iff (!sys_srst_n)
      wdt_enable_i && wdt_zero
      |=> wdt_cnt_r == $past(watchdog_reload_value_i))
      else $error("watchdog did not reload");
   AST_POR_ONCE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !$past(por_seen_r) |-> !por_seen_r)
      else $error("power-on seen again");
   AST_WDT_RST: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      wdt_rst_r |-> $past(wdt_int_r) && $past(wdt_reset_enable_i))
      else $error("watchdog reset without cause");
   AST_SWREQ: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      swreq_r |=> !core_rst_n_o ##[1:6] core_fetch_o)
      else $error("software reset sequence wrong");
   AST_UNIT: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $fell(per_bits[0]) && sys_srst_n && sys_arst_n
      |=> ##1 !unit_rst_n_o[0])
      else $error("unit reset missing");
   AST_FETCH: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $rose(sys_srst_n) |-> ##2 core_fetch_o)
      else $error("fetch not started");

   COV_WDT: cover property (@(posedge core_clk_i) wdt_rst_r);
   COV_DROOP: cover property (@(posedge core_clk_i) droop_rst);
   COV_WDT_CLR: cover property (@(posedge core_clk_i) wdt_int_r
      && wdt_int_clear_i);
   COV_SW: cover property (@(posedge core_clk_i) swreq_r ##[1:8] core_fetch_o);
   COV_UNIT: cover property (@(posedge core_clk_i) !unit_rst_n_o[0]
      && core_rst_n_o);
endmodule

// ===== rsc_supply_model.sv
// far-side model: reset pin driver, supply droop monitor, test pins
`timescale 1ns/1ps
module rsc_supply_model (
   input wire logic core_clk_i,
   output logic ext_rst_n_o,
   output logic supply_droop_o,
   output logic test_mode_pin_0_o,
   output logic test_mode_pin_1_o
);
   // shortest pin pulse the model will ever produce
   localparam int T_MIN = 4;
   // test pins grounded on the board, never driven high
   initial begin
      ext_rst_n_o = 1'b1;
      supply_droop_o = 1'b0;
      test_mode_pin_0_o = 1'b0;
      test_mode_pin_1_o = 1'b0;
   end
   // short requests stretched up to the minimum width
   task automatic pin_pulse(input int w);
      @(posedge core_clk_i) ext_rst_n_o <= 1'b0;
      repeat ((w < T_MIN) ? T_MIN : w) @(posedge core_clk_i);
      ext_rst_n_o <= 1'b1;
   endtask
   // droop level held for w cycles
   task automatic droop_pulse(input int w);
      @(posedge core_clk_i) supply_droop_o <= 1'b1;
      repeat (w) @(posedge core_clk_i);
      supply_droop_o <= 1'b0;
   endtask
endmodule

// ===== rsc_top_tb.sv
// self-checking testbench for the reset source controller
`timescale 1ns/1ps
module rsc_top_tb;
   logic core_clk_i, rstn_i, droop_en, sys_req, wdt_en, wdt_ren, cause_clr;
   logic [95:0] per, unit_n;
   logic [31:0] reload, seed;
   logic ext_n, droop, tm0, tm1, core_n, tap_n, per_n, fetch, d_int, w_int;
   logic tm_bad, wdt_svc, wdt_clr;
   logic [5:0] cause, cause_mask;
   int mismatches, checks, exp_cause, idx, n;

   rsc_supply_model ext_u (.core_clk_i(core_clk_i), .ext_rst_n_o(ext_n),
      .supply_droop_o(droop), .test_mode_pin_0_o(tm0),
      .test_mode_pin_1_o(tm1));

   rsc_top dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .ext_rst_n_i(ext_n), .supply_droop_i(droop),
      .droop_reset_enable_i(droop_en), .system_reset_request_i(sys_req),
      .periph_reset_ctrl_0_i(per[31:0]), .periph_reset_ctrl_1_i(per[63:32]),
      .periph_reset_ctrl_2_i(per[95:64]), .wdt_enable_i(wdt_en),
      .wdt_reset_enable_i(wdt_ren), .watchdog_reload_value_i(reload),
      .wdt_int_clear_i(wdt_clr), .wdt_service_i(wdt_svc),
      .cause_clear_i(cause_clr), .cause_clear_mask_i(cause_mask),
      .test_mode_pin_0_i(tm0), .test_mode_pin_1_i(tm1),
      .core_rst_n_o(core_n), .tap_rst_n_o(tap_n), .periph_rst_n_o(per_n),
      .unit_rst_n_o(unit_n), .core_fetch_o(fetch), .droop_int_o(d_int),
      .wdt_int_o(w_int), .reset_cause_reg_o(cause),
      .test_mode_bad_o(tm_bad));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [95:0] seen, exp, input string nm);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // sample 1 ns after the edge so registered outputs have landed
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask
   // bounded wait: 0 core reset, 1 fetch pulse, 2 watchdog interrupt
   task automatic wait_sig(input int sel, input logic v, input int lim);
      n = 0;
      while (n < lim && (sel == 0 ? core_n : sel == 1 ? fetch : w_int) !== v)
      begin
         tick(1);
         n++;
      end
      chk(n < lim, 1'b1, "wait bound");
   endtask
   // model: cause bit joins the sticky set once fetch has started
   task automatic fetch_done(input int b);
      wait_sig(1, 1'b1, 200);
      tick(3);
      exp_cause = exp_cause | (1 << b);
      chk(core_n, 1'b1, "core release");
      chk(cause, exp_cause[5:0], "cause");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   // whole run needs a few hundred cycles; 50000 is ample
   initial begin
      #400000;
      mismatches++;
      end_of_test();
   end
   initial begin
      rstn_i = 1'b0;
      {droop_en, sys_req, wdt_en, wdt_ren, cause_clr} = 5'h00;
      {wdt_svc, wdt_clr} = 2'h0;
      cause_mask = 6'h3f;
      per = '0;
      reload = 32'h10;
      seed = 32'h2555;
      mismatches = 0;
      checks = 0;
      exp_cause = 0;
      repeat (20) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      tick(1);
      chk(tap_n, 1'b1, "tap release");
      fetch_done(rsc_pkg::CAUSE_POR);
      chk(tm_bad, 1'b0, "test mode");
      // pin reset leaves the test port alone
      fork
         ext_u.pin_pulse(6);
         begin
            tick(3);
            chk(core_n, 1'b0, "pin core");
            chk(tap_n, 1'b1, "pin tap");
            chk(per_n, 1'b0, "pin periph");
         end
      join
      fetch_done(rsc_pkg::CAUSE_EXT);
      // droop while disabled only interrupts
      fork
         ext_u.droop_pulse(10);
         begin
            tick(4);
            chk(d_int, 1'b1, "droop int");
            chk(core_n, 1'b1, "droop off");
         end
      join
      tick(3);
      @(posedge core_clk_i) droop_en <= 1'b1;
      fork
         ext_u.droop_pulse(12);
         begin
            tick(10);
            chk(core_n, 1'b0, "droop held");
         end
      join
      @(posedge core_clk_i) droop_en <= 1'b0;
      fetch_done(rsc_pkg::CAUSE_DRP);
      // one-cycle system request
      @(posedge core_clk_i) sys_req <= 1'b1;
      @(posedge core_clk_i) sys_req <= 1'b0;
      tick(1);
      chk(core_n, 1'b0, "sys req");
      fetch_done(rsc_pkg::CAUSE_SW);
      // random peripheral bits, set then clear
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         // bit 0 first so its falling-edge assertion is exercised
         idx = (k == 0) ? 0 : seed % 96;
         @(posedge core_clk_i) per[idx] <= 1'b1;
         tick(3);
         chk(unit_n, ~(96'h1 << idx), "unit set");
         chk(core_n, 1'b1, "unit core");
         @(posedge core_clk_i) per[idx] <= 1'b0;
         tick(2);
         chk(unit_n, ~(96'h1 << idx), "unit after clear");
         tick(2);
         chk(unit_n, ~96'h0, "unit clear");
      end
      // watchdog loaded once with a short random reload
      seed = lfsr(seed);
      @(posedge core_clk_i) begin
         reload <= 32'h10 + seed[3:0];
         wdt_en <= 1'b1;
         wdt_ren <= 1'b1;
         wdt_svc <= 1'b1;
      end
      @(posedge core_clk_i) wdt_svc <= 1'b0;
      tick(1);
      wait_sig(2, 1'b1, 3 * reload + 60);
      chk(core_n, 1'b1, "wdt first");
      // interrupt cleared in time: the next zero only interrupts again
      @(posedge core_clk_i) wdt_clr <= 1'b1;
      @(posedge core_clk_i) wdt_clr <= 1'b0;
      tick(1);
      chk(w_int, 1'b0, "wdt int clear");
      wait_sig(2, 1'b1, reload + 20);
      chk(core_n, 1'b1, "wdt no reset");
      // left pending, the following zero resets the system
      wait_sig(0, 1'b0, reload + 40);
      @(posedge core_clk_i) wdt_en <= 1'b0;
      chk(n + 4 > reload && n < reload + 6, 1'b1, "reload gap");
      fetch_done(rsc_pkg::CAUSE_WDT);
      // clear a random subset of sticky flags, then the rest
      seed = lfsr(seed);
      @(posedge core_clk_i) begin
         cause_clr <= 1'b1;
         cause_mask <= seed[5:0];
      end
      @(posedge core_clk_i) cause_clr <= 1'b0;
      tick(2);
      chk(cause, exp_cause[5:0] & ~seed[5:0], "cause part");
      @(posedge core_clk_i) begin
         cause_clr <= 1'b1;
         cause_mask <= 6'h3f;
      end
      @(posedge core_clk_i) cause_clr <= 1'b0;
      tick(2);
      chk(cause, 6'h00, "cause clear");
      end_of_test();
   end
endmodule
